// File: inc/cal_pkg.sv
// Constants, register map and factory waveform contents for the calibration generator.
// Assumes a 250 MHz system clock and a 32-bit Avalon-MM register port.
package cal_pkg;

  // Waveform memory geometry.
  localparam int REGION_BITS = 3;
  localparam int SAMPLE_ADDR_BITS = 15;
  localparam int MEM_ADDR_BITS = REGION_BITS + SAMPLE_ADDR_BITS;
  localparam int REGION_SAMPLES = 32768;
  localparam int SAMPLE_W = 16;
  localparam int CONV_W = 24;

  // Channel gain geometry: code 0 is -95.0 dB, each code adds 0.5 dB.
  localparam int CHAN_MAX = 32;
  localparam int CHAN_BITS = 5;
  localparam int GAIN_W = 8;
  localparam logic [GAIN_W-1:0] GAIN_CODE_MAX = 8'hfd;
  localparam logic [GAIN_W-1:0] GAIN_RST = 8'hbe;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h08;
  localparam logic [7:0] OFS_MEM_DATA = 8'h0c;
  localparam logic [7:0] OFS_GAIN_SEL = 8'h10;
  localparam logic [7:0] OFS_GAIN_VAL = 8'h14;

  // Control register fields.
  localparam int CTRL_GEN_EN = 0;
  localparam int CTRL_INJ_EN = 1;
  localparam int CTRL_SRC_EXT = 2;
  localparam int CTRL_OS128 = 3;
  localparam int CTRL_SEL_LSB = 4;
  localparam logic [31:0] CTRL_MASK = 32'h0000_007f;

  // Status register fields.
  localparam int STAT_RUN = 16;
  localparam int STAT_SETTLE = 17;

  // Converter clock edges per output sample for each oversampling ratio.
  localparam logic [7:0] OS64_EDGES = 8'h40;
  localparam logic [7:0] OS128_EDGES = 8'h80;

  // Gain settling time.
  localparam int CLK_KHZ = 250000;
  localparam int GAIN_SETTLE_MS = 18;
  localparam int GAIN_SETTLE_CYC = GAIN_SETTLE_MS * CLK_KHZ;
  localparam int SETTLE_W = 23;

  // Factory waveform figures.
  localparam longint SINE_CYCLES = 544;
  localparam longint SINE_PEAK = 64'h4026;
  localparam logic [SAMPLE_W-1:0] NEG_DC = 16'hfbf4;
  localparam logic [SAMPLE_W-1:0] POS_DC = 16'h040c;
  localparam longint SAW_CYCLES = 50;
  localparam longint SAW_PEAK = 64'h7fff;

  // Factory content of one memory word; regions five to eight stay blank.
  function automatic logic [SAMPLE_W-1:0] factory_sample(input logic [MEM_ADDR_BITS-1:0] a);
    longint n;
    longint p;
    longint x;
    longint y;
    longint v;
    n = longint'(a[SAMPLE_ADDR_BITS-1:0]);
    v = 0;
    case (a[MEM_ADDR_BITS-1:SAMPLE_ADDR_BITS])
      3'h0: begin
        // Rational sine approximation over each half period.
        p = (n * SINE_CYCLES) % REGION_SAMPLES;
        x = p % (REGION_SAMPLES / 2);
        y = x * ((REGION_SAMPLES / 2) - x);
        v = (SINE_PEAK * 16 * y) / ((longint'(5) << 28) - 4 * y);
        if (p >= REGION_SAMPLES / 2) begin
          v = -v;
        end
      end
      3'h1: v = longint'(signed'(NEG_DC));
      3'h2: v = longint'(signed'(POS_DC));
      3'h3: begin
        p = (n * SAW_CYCLES) % REGION_SAMPLES;
        v = (p * 2 * SAW_PEAK) / (REGION_SAMPLES - 1) - SAW_PEAK;
      end
      default: v = 0;
    endcase
    return v[SAMPLE_W-1:0];
  endfunction : factory_sample

endpackage : cal_pkg

// File: hdl/wave_mem.sv
// Waveform sample memory with one write port and two registered read ports.
// Assumes all ports share one clock; contents start as the factory image.
`timescale 1ns/1ns
module wave_mem #(
  parameter int AW = cal_pkg::MEM_ADDR_BITS,
  parameter int DW = cal_pkg::SAMPLE_W
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_a_addr,
  output logic [DW-1:0] rd_a_data,
  input wire logic [AW-1:0] rd_b_addr,
  output logic [DW-1:0] rd_b_data
);
  import cal_pkg::*;

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Load the factory image before operation starts.
  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = factory_sample(MEM_ADDR_BITS'(i));
    end
  end

  // Write port; a plain clocked process, since the image loader also writes the array.
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Both read ports, each read registered.
  always_ff @(posedge clk) begin
    rd_a_data <= mem[rd_a_addr];
    rd_b_data <= mem[rd_b_addr];
  end

endmodule : wave_mem

// File: hdl/gain_store.sv
// Per-channel gain codes with a registered read-back port and a flat output.
// Assumes writers have already clamped the code into range.
`timescale 1ns/1ns
module gain_store #(
  parameter int CHANS = cal_pkg::CHAN_MAX,
  parameter int CW = cal_pkg::CHAN_BITS,
  parameter int GW = cal_pkg::GAIN_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [CW-1:0] wr_chan,
  input wire logic [GW-1:0] wr_gain,
  input wire logic [CW-1:0] rd_chan,
  output logic [GW-1:0] rd_gain,
  output logic [CHANS*GW-1:0] gains_flat
);
  import cal_pkg::*;

  logic [GW-1:0] gain_r [0:CHANS-1];

  // Each channel keeps its own code; reset gives 0 dB everywhere.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < CHANS; i++) begin
        gain_r[i] <= GAIN_RST;
      end
      rd_gain <= '0;
    end else begin
      if (wr_en && (int'(wr_chan) < CHANS)) begin
        gain_r[wr_chan] <= wr_gain;
      end
      rd_gain <= (int'(rd_chan) < CHANS) ? gain_r[rd_chan] : '0;
    end
  end

  // Flatten the codes for the analog gain stages.
  always_comb begin
    for (int i = 0; i < CHANS; i++) begin
      gains_flat[i*GW +: GW] = gain_r[i];
    end
  end

endmodule : gain_store

// File: hdl/cal_waveform_generator.sv
// Calibration signal generator: stored waveforms to a DAC, injection control, channel gains.
// Assumes an Avalon-MM master on clk and a converter sampling clock arriving on a pin.
//
// Overview of operation
// - Memory holds eight 32K-sample waveform regions, waveform one lowest.
// - Each region is 32,768 samples of 16 bits each.
// - When enabled, the selected waveform loops to the DAC without gaps.
// - Software picks which of eight waveforms plays.
// - Software turns injection on or off and picks generator or external source.
// - Injection routes one common signal to all channels together.
// - Each of up to 32 channels has its own gain setting.
// - Gain spans -95.0 dB to +31.5 dB in 0.5 dB steps.
// - Only regions one to four are factory filled; five to eight loadable.
// - Factory: sine 544 cycles, two DC levels, 50-cycle sawtooth, given peaks.
// - Full-scale 16-bit sample equals full-scale 24-bit converter value.
// - Sample advance follows oversampling; 128x steps two samples per tick, same pace as 64x.
`timescale 1ns/1ns
module cal_waveform_generator #(
  parameter int CHANS = cal_pkg::CHAN_MAX,
  parameter int SETTLE_CYC = cal_pkg::GAIN_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic conv_clk,
  output logic [cal_pkg::SAMPLE_W-1:0] dac_data,
  output logic dac_load,
  output logic [cal_pkg::CONV_W-1:0] adc_equiv,
  output logic cal_inject_on,
  output logic cal_src_ext,
  output logic [CHANS-1:0] cal_route,
  output logic [CHANS*cal_pkg::GAIN_W-1:0] gain_flat,
  output logic gain_settling
);
  import cal_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Merge written bytes into an old register value.
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] ctrl_r;
  logic [MEM_ADDR_BITS-1:0] mem_addr_r;
  logic [CHAN_BITS-1:0] gain_sel_r;
  logic [SETTLE_W-1:0] settle_r;
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic [7:0] edge_cnt_r;
  logic [SAMPLE_ADDR_BITS-1:0] samp_r;
  logic [REGION_BITS-1:0] sel_prev_r;
  logic [SAMPLE_W-1:0] dac_r;
  logic dac_load_r;
  logic [CONV_W-1:0] adc_r;
  logic [SAMPLE_W-1:0] gen_data;
  logic [SAMPLE_W-1:0] bus_mem_data;
  logic [GAIN_W-1:0] gain_rd;

  //////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave decode.

  // One wait cycle per access; the access completes while waitrequest is low.
  wire req = avs_read | avs_write;
  wire done = req & ack_r;
  wire wr_done = avs_write & ack_r;
  wire rd_done = avs_read & ack_r;
  wire hit_ctrl = (avs_address == OFS_CTRL);
  wire hit_status = (avs_address == OFS_STATUS);
  wire hit_maddr = (avs_address == OFS_MEM_ADDR);
  wire hit_mdata = (avs_address == OFS_MEM_DATA);
  wire hit_gsel = (avs_address == OFS_GAIN_SEL);
  wire hit_gval = (avs_address == OFS_GAIN_VAL);
  wire [31:0] wr_merged_ctrl = be_merge(ctrl_r, avs_writedata, avs_byteenable) & CTRL_MASK;
  wire [31:0] wr_merged_maddr = be_merge(32'(mem_addr_r), avs_writedata, avs_byteenable);
  wire [31:0] wr_merged_gsel = be_merge(32'(gain_sel_r), avs_writedata, avs_byteenable);
  wire [31:0] wr_merged_gval = be_merge(32'(gain_rd), avs_writedata, avs_byteenable);
  wire mem_wr = wr_done & hit_mdata;
  wire gain_wr = wr_done & hit_gval;
  wire mem_step = done & hit_mdata;

  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata = rdata_r;

  // Handshake phase toggles so each request sees exactly one wait cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control fields.

  wire [REGION_BITS-1:0] sel = ctrl_r[CTRL_SEL_LSB +: REGION_BITS];
  wire gen_en = ctrl_r[CTRL_GEN_EN];
  wire os128 = ctrl_r[CTRL_OS128];

  // Control register and memory/gain pointers, written at the completing edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= '0;
      mem_addr_r <= '0;
      gain_sel_r <= '0;
    end else begin
      if (wr_done && hit_ctrl) begin
        ctrl_r <= wr_merged_ctrl;
      end
      if (wr_done && hit_maddr) begin
        mem_addr_r <= wr_merged_maddr[MEM_ADDR_BITS-1:0];
      end else if (mem_step) begin
        mem_addr_r <= mem_addr_r + 1'b1;
      end
      if (wr_done && hit_gsel) begin
        gain_sel_r <= wr_merged_gsel[CHAN_BITS-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data.

  // Read mux sampled on the wait cycle; the value stands through the completing edge.
  always_comb begin
    rdata_nxt = '0;
    if (hit_ctrl) begin
      rdata_nxt = ctrl_r;
    end else if (hit_status) begin
      rdata_nxt[SAMPLE_ADDR_BITS-1:0] = samp_r;
      rdata_nxt[STAT_RUN] = gen_en;
      rdata_nxt[STAT_SETTLE] = gain_settling;
    end else if (hit_maddr) begin
      rdata_nxt[MEM_ADDR_BITS-1:0] = mem_addr_r;
    end else if (hit_mdata) begin
      rdata_nxt[SAMPLE_W-1:0] = bus_mem_data;
    end else if (hit_gsel) begin
      rdata_nxt[CHAN_BITS-1:0] = gain_sel_r;
    end else if (hit_gval) begin
      rdata_nxt[GAIN_W-1:0] = gain_rd;
    end
  end

  // Capture read data on the first cycle of a read.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= '0;
    end else if (avs_read && !ack_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel gains.

  wire [GAIN_W-1:0] gain_clamped = (wr_merged_gval[GAIN_W-1:0] > GAIN_CODE_MAX) ?
                                   GAIN_CODE_MAX : wr_merged_gval[GAIN_W-1:0];

  gain_store #(
    .CHANS(CHANS),
    .CW(CHAN_BITS),
    .GW(GAIN_W)
  ) gain_store_inst (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(gain_wr),
    .wr_chan(gain_sel_r),
    .wr_gain(gain_clamped),
    .rd_chan(gain_sel_r),
    .rd_gain(gain_rd),
    .gains_flat(gain_flat)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_r <= '0;
    end else if (gain_wr) begin
      settle_r <= SETTLE_W'(SETTLE_CYC);
    end else if (settle_r != '0) begin
      settle_r <= settle_r - 1'b1;
    end
  end

  assign gain_settling = (settle_r != '0);

  //////////////////////////////////////////////////////////////////////////////
  // Waveform memory.

  wire restart = ~gen_en | (sel != sel_prev_r);

  // region-major addressing; a restart reads sample zero at once.
  wire [MEM_ADDR_BITS-1:0] gen_addr = {sel, restart ? SAMPLE_ADDR_BITS'(0) : samp_r};

  wave_mem #(
    .AW(MEM_ADDR_BITS),
    .DW(SAMPLE_W)
  ) wave_mem_inst (
    .clk(clk),
    .wr_en(mem_wr),
    .wr_addr(mem_addr_r),
    .wr_data(avs_writedata[SAMPLE_W-1:0]),
    .rd_a_addr(gen_addr),
    .rd_a_data(gen_data),
    .rd_b_addr(mem_addr_r),
    .rd_b_data(bus_mem_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Converter clock pacing.

  // Two-stage synchroniser, then edge detect on the settled stages.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= conv_clk;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  wire conv_edge = s2_r & ~s3_r;
  wire [7:0] edges_per_out = os128 ? OS128_EDGES : OS64_EDGES;
  wire tick = conv_edge & (edge_cnt_r == edges_per_out - 8'h01);
  wire [SAMPLE_ADDR_BITS-1:0] step = os128 ? SAMPLE_ADDR_BITS'(2) : SAMPLE_ADDR_BITS'(1);

  // Counts converter clock edges within one output sample period.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_cnt_r <= '0;
    end else if (tick || edge_cnt_r >= edges_per_out) begin
      edge_cnt_r <= '0;
    end else if (conv_edge) begin
      edge_cnt_r <= edge_cnt_r + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sample sequencer and DAC.

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      samp_r <= '0;
      sel_prev_r <= '0;
      dac_r <= '0;
      dac_load_r <= 1'b0;
    end else begin
      sel_prev_r <= sel;
      dac_load_r <= tick & gen_en & ~restart;
      if (restart) begin
        samp_r <= '0;
      end else if (tick) begin
        dac_r <= gen_data;
        samp_r <= samp_r + step;
      end
    end
  end

  assign dac_data = dac_r;
  assign dac_load = dac_load_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adc_r <= '0;
    end else begin
      adc_r <= {dac_r, {(CONV_W-SAMPLE_W){1'b0}}};
    end
  end

  assign adc_equiv = adc_r;

  //////////////////////////////////////////////////////////////////////////////
  // Injection relays.

  assign cal_inject_on = ctrl_r[CTRL_INJ_EN];
  assign cal_src_ext = ctrl_r[CTRL_SRC_EXT];

  assign cal_route = {CHANS{ctrl_r[CTRL_INJ_EN]}};

endmodule : cal_waveform_generator

// File: tb/cal_waveform_generator_chk.sv
// Concurrent checks on the calibration generator's top-level ports.
// Assumes one clock, clk, and the asynchronous active-low reset rst_b.
`timescale 1ns/1ns
module cal_waveform_generator_chk #(
  parameter int CHANS = 32,
  parameter int SETTLE_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_write,
  input wire logic avs_read,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic [cal_pkg::SAMPLE_W-1:0] dac_data,
  input wire logic dac_load,
  input wire logic [cal_pkg::CONV_W-1:0] adc_equiv,
  input wire logic cal_inject_on,
  input wire logic cal_src_ext,
  input wire logic [CHANS-1:0] cal_route,
  input wire logic [CHANS*cal_pkg::GAIN_W-1:0] gain_flat,
  input wire logic gain_settling
);
  import cal_pkg::*;
  logic [31:0] settle_cnt_r;
  logic gain_over;
  wire ctrl_wr = avs_write && !avs_waitrequest && avs_address == OFS_CTRL;
  ////////////////////////////////////////////////////////////////////////////////
  // Counts the cycles for which the settling flag has been high.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_cnt_r <= '0;
    end else begin
      settle_cnt_r <= gain_settling ? settle_cnt_r + 32'h1 : '0;
    end
  end
  // Flags any channel holding a code above the top gain step.
  always_comb begin
    gain_over = 1'b0;
    for (int i = 0; i < CHANS; i++) begin
      if (gain_flat[GAIN_W*i +: GAIN_W] > GAIN_CODE_MAX) begin
        gain_over = 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_ctrl_wr;
    ctrl_wr && avs_byteenable[0];
  endsequence
  sequence s_gain_wr;
    avs_write && !avs_waitrequest && avs_address == OFS_GAIN_VAL;
  endsequence
  property p_route;
    cal_route == {CHANS{cal_inject_on}};
  endproperty
  a_route: assert property (p_route) else $error("route bits differ");
  property p_relay_set;
    s_ctrl_wr |=> cal_inject_on == $past(avs_writedata[CTRL_INJ_EN])
      && cal_src_ext == $past(avs_writedata[CTRL_SRC_EXT]);
  endproperty
  a_relay_set: assert property (p_relay_set) else $error("relay not set");
  property p_relay_hold;
    !$past(ctrl_wr) |-> $stable(cal_src_ext) && $stable(cal_inject_on);
  endproperty
  a_relay_hold: assert property (p_relay_hold) else $error("relay moved");
  property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_load_pulse;
    dac_load |=> !dac_load;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load too long");
  property p_load_cause;
    $changed(dac_data) |-> ##[0:1] dac_load;
  endproperty
  a_load_cause: assert property (p_load_cause) else $error("sample without load");
  property p_equiv;
    adc_equiv == {$past(dac_data), 8'h00};
  endproperty
  a_equiv: assert property (p_equiv) else $error("converter value wrong");
  property p_gain_max;
    !gain_over;
  endproperty
  a_gain_max: assert property (p_gain_max) else $error("gain code too high");
  property p_settle_start;
    s_gain_wr |=> ##[0:2] gain_settling;
  endproperty
  a_settle_start: assert property (p_settle_start) else $error("no settling");
  property p_settle_len;
    $fell(gain_settling) |-> settle_cnt_r == SETTLE_CYC;
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("settling length");
endmodule : cal_waveform_generator_chk
bind cal_waveform_generator cal_waveform_generator_chk #(
  .CHANS(CHANS),
  .SETTLE_CYC(SETTLE_CYC)
) cal_waveform_generator_chk_inst (
  .clk, .rst_b, .avs_address, .avs_write, .avs_read, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .dac_data, .dac_load, .adc_equiv, .cal_inject_on, .cal_src_ext,
  .cal_route, .gain_flat, .gain_settling
);

// File: tb/dac_model.sv
// Model of the DAC and converter clock on the far side of the generator.
// Assumes the load strobe is a one-cycle pulse on clk.
`timescale 1ns/1ns
module dac_model #(
  parameter int HALF_NS = 9
) (
  input wire logic clk,
  output logic conv_clk,
  input wire logic [cal_pkg::SAMPLE_W-1:0] dac_data,
  input wire logic dac_load,
  output logic [cal_pkg::SAMPLE_W-1:0] dac_level,
  output int load_count
);
  import cal_pkg::*;
  // Free-running sampling clock, out of phase with clk on purpose.
  initial begin
    conv_clk = 1'b0;
    #3;
    forever #(HALF_NS) conv_clk = ~conv_clk;
  end
  initial begin
    dac_level = '0;
    load_count = 0;
  end
  always @(posedge clk) begin
    if (dac_load === 1'b1) begin
      dac_level <= dac_data;
      load_count <= load_count + 1;
    end
  end
endmodule : dac_model

// File: tb/cal_waveform_generator_tb.sv
// Self-checking bench for the calibration generator.
// Assumes the DAC model and the bound checker; settling is shortened to 20 cycles.
`timescale 1ns/1ns
module cal_waveform_generator_tb;
  import cal_pkg::*;
  logic clk;
  logic rst_b;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic conv_clk;
  logic [SAMPLE_W-1:0] dac_data;
  logic [SAMPLE_W-1:0] dac_level;
  logic dac_load;
  logic [CONV_W-1:0] adc_equiv;
  logic cal_inject_on;
  logic cal_src_ext;
  logic [31:0] cal_route;
  logic [CHAN_MAX*GAIN_W-1:0] gain_flat;
  logic gain_settling;
  logic [31:0] q;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int loads;
  logic [17:0] ma [6] = '{18'h00000, 18'h08000, 18'h0ffff, 18'h10000, 18'h18000, 18'h20000};
  logic [15:0] mv [6] = '{16'h0000, 16'hfbf4, 16'hfbf4, 16'h040c, 16'h8001, 16'h0000};
  logic [15:0] wv [3] = '{16'h1a01, 16'h2b02, 16'h3c03};
  cal_waveform_generator #(.SETTLE_CYC(20)) cal_waveform_generator_inst (
    .clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .conv_clk, .dac_data, .dac_load, .adc_equiv,
    .cal_inject_on, .cal_src_ext, .cal_route, .gain_flat, .gain_settling
  );
  dac_model dac_model_inst (
    .clk, .conv_clk, .dac_data, .dac_load, .dac_level, .load_count(loads)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // System clock at 250 MHz.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  // One bus cycle, held until the rising edge that sees waitrequest low; read data lands in q.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task end_of_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // Waits for the DAC to take a sample, then checks the converter value.
  task get_load(output logic [15:0] v);
    int n;
    n = loads;
    do @(negedge clk); while (loads == n);
    v = dac_level;
    chk("equiv", 32'(adc_equiv), {8'h0, v, 8'h00});
  endtask : get_load
  task wait_settle;
    do @(negedge clk); while (gain_settling !== 1'b0);
    @(posedge clk);
  endtask : wait_settle
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    bus(1'b1, OFS_CTRL, 32'h6);
    chk("route", cal_route, 32'hffff_ffff);
    chk("src", 32'(cal_src_ext), 32'h1);
    bus(1'b1, OFS_CTRL, 32'h2);
    chk("src", 32'(cal_src_ext), 32'h0);
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, OFS_CTRL, 32'(s) << CTRL_SEL_LSB);
      bus(1'b0, OFS_CTRL, 32'h0);
      chk("sel", q, 32'(s) << CTRL_SEL_LSB);
    end
    chk("inject", 32'(cal_inject_on), 32'h0);
    bus(1'b0, 8'hfc, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task t_mem;
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, OFS_MEM_ADDR, 32'(ma[i]));
      bus(1'b0, OFS_MEM_DATA, 32'h0);
      chk("mem", q, 32'(mv[i]));
    end
    bus(1'b0, OFS_MEM_ADDR, 32'h0);
    chk("mem_addr", q, 32'h20001);
    $display("t_mem done");
  endtask : t_mem
  task t_gain;
    bus(1'b1, OFS_GAIN_SEL, 32'd31);
    bus(1'b1, OFS_GAIN_VAL, 32'hff);
    chk("settling", 32'(gain_settling), 32'h1);
    wait_settle;
    bus(1'b0, OFS_GAIN_VAL, 32'h0);
    chk("gain31", q, 32'hfd);
    chk("flat31", 32'(gain_flat[255:248]), 32'hfd);
    chk("flat0", 32'(gain_flat[7:0]), 32'hbe);
    bus(1'b1, OFS_GAIN_SEL, 32'h0);
    bus(1'b1, OFS_GAIN_VAL, 32'h0);
    wait_settle;
    chk("flat0", 32'(gain_flat[7:0]), 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status", q & 32'h20000, 32'h0);
    $display("t_gain done");
  endtask : t_gain
  task t_gen;
    logic [15:0] v;
    int n;
    bus(1'b1, OFS_MEM_ADDR, 32'h28000);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, OFS_MEM_DATA, 32'(wv[i]));
    end
    bus(1'b1, OFS_CTRL, 32'h51);
    for (int i = 0; i < 3; i++) begin
      get_load(v);
      chk("dac64", 32'(v), 32'(wv[i]));
    end
    @(posedge clk);
    bus(1'b1, OFS_CTRL, 32'h61);
    get_load(v);
    chk("blank", 32'(v), 32'h0);
    @(posedge clk);
    bus(1'b1, OFS_CTRL, 32'h59);
    get_load(v);
    chk("dac128", 32'(v), 32'(wv[0]));
    get_load(v);
    chk("dac128", 32'(v), 32'(wv[2]));
    @(posedge clk);
    bus(1'b1, OFS_CTRL, 32'h0);
    n = loads;
    repeat (700) @(posedge clk);
    chk("idle", 32'(loads - n), 32'h0);
    $display("t_gen done");
  endtask : t_gen
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, then each scenario in turn.
  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("rst_gain", 32'(gain_flat[39:32]), 32'hbe);
    chk("rst_dac", 32'(dac_data), 32'h0);
    t_regs;
    t_mem;
    t_gain;
    t_gen;
    end_of_test;
  end
  // Cuts a hang short well beyond the expected run length.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test;
    end
  end
endmodule : cal_waveform_generator_tb
